// ===== src/tws_pkg.sv
// Package with the register map, field positions, timing counts and state type of the port.
package tws_pkg;

  // ------------------------------------------------------------------
  // Register addresses on the special-function register bus.
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_SLAVE = 8'h9B;
  localparam logic [7:0] ADDR_CTRL = 8'hE0;
  localparam logic [7:0] ADDR_DATA = 8'hE1;

  // ------------------------------------------------------------------
  // Reset values.
  // ------------------------------------------------------------------
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h55;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ------------------------------------------------------------------
  // Control register field positions.
  // ------------------------------------------------------------------
  localparam int CTRL_DATA_OUT = 7;
  localparam int CTRL_CLOCK_OUT = 6;
  localparam int CTRL_DRIVE_EN = 5;
  localparam int CTRL_DATA_IN = 4;
  localparam int CTRL_MASTER = 3;
  localparam int CTRL_RESET = 2;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_DONE = 0;

  // ------------------------------------------------------------------
  // Timing: spike rejection window and its length in core clocks.
  // ------------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 200;
  localparam int FILT_NS = 50;
  localparam int FILT_CYC = (FILT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int FILT_W = 4;
  localparam int BYTE_BITS = 8;
  localparam int CNT_W = 4;

  // ------------------------------------------------------------------
  // Slave sequencer states.
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PUSH,
    ST_ACK,
    ST_WAIT,
    ST_RX,
    ST_TX,
    ST_TXACK
  } tws_state_type;

endpackage

// ===== src/tws_fifo2.sv
// Two-entry valid/ready buffer built from flip-flops.
`timescale 1ns/10ps
module tws_fifo2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and count; a flush empties the buffer at once.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (flush) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // tws_fifo2

// ===== src/tws_port.sv
// Two-wire serial port: software master pin control and hardware byte slave.
`timescale 1ns/10ps

module tws_port (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe
);

  // ------------------------------------------------------------------
  // Declarations.
  // ------------------------------------------------------------------
  tws_pkg::tws_state_type state_q;
  logic [7:0] slave_address_reg_q;
  logic [7:0] byte_data_reg_q;
  logic master_select_bit_q;
  logic iface_reset_bit_q;
  logic direction_status_bit_q;
  logic byte_done_flag_q;
  logic byte_done_flag_d;
  logic data_drive_enable_q;
  logic data_out_bit_q;
  logic clock_out_bit_q;
  logic data_in_bit_q;
  logic [7:0] sfr_rdata_q;
  logic [7:0] shift_q;
  logic [tws_pkg::CNT_W-1:0] cnt_q;
  logic tx_nack_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] filt_q;
  logic [1:0] filt_p_q;
  logic [tws_pkg::FILT_W-1:0] filt_cnt_q [2];
  logic lnk_bit_q;
  logic lnk_tog_q;
  logic [2:0] tog_sync_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic slave_off;
  logic ctrl_wr;
  logic data_rd;
  logic data_wr;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic tx_byte_done;
  logic sda_out_q;
  logic sda_oe_q;
  logic scl_out_q;
  logic scl_oe_q;

  // Address decode shared by the write and read paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  assign ctrl_wr = sfr_wr & hit(sfr_addr, tws_pkg::ADDR_CTRL);
  assign data_wr = sfr_wr & hit(sfr_addr, tws_pkg::ADDR_DATA);
  assign data_rd = sfr_rd & hit(sfr_addr, tws_pkg::ADDR_DATA);
  assign slave_off = master_select_bit_q | iface_reset_bit_q;

  // ------------------------------------------------------------------
  // Link domain: data sampled on the clock line's own rising edge.
  // ------------------------------------------------------------------
  // The line itself clocks this flop, so the capture is exact even when the
  // high phase is shorter than a core clock; the toggle tells the core side.
  always_ff @(posedge serial_clock_in or negedge rst_b) begin
    if (!rst_b) begin
      lnk_bit_q <= 1'b0;
      lnk_tog_q <= 1'b0;
    end else begin
      lnk_bit_q <= serial_data_in;
      lnk_tog_q <= ~lnk_tog_q;
    end
  end

  // Toggle crossing; stage 0 feeds only stage 1, the edge uses stages 1 and 2.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_sync_q <= 3'h0;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], lnk_tog_q};
    end
  end

  // The sampled bit is stable long before the crossed toggle arrives.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_in_bit_q <= 1'b0;
    end else if (tog_sync_q[2] != tog_sync_q[1]) begin
      data_in_bit_q <= lnk_bit_q;
    end
  end

  // ------------------------------------------------------------------
  // Input synchronisers and spike filters for the slave sequencer.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], serial_clock_in};
      sda_sync_q <= {sda_sync_q[0], serial_data_in};
    end
  end

  // A level is accepted only after it has held for the whole window.
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic raw;
    assign raw = (i == 0) ? scl_sync_q[1] : sda_sync_q[1];
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        filt_q[i] <= 1'b1;
        filt_cnt_q[i] <= '0;
      end else if (raw == filt_q[i]) begin
        filt_cnt_q[i] <= '0;
      end else if (filt_cnt_q[i] == tws_pkg::FILT_W'(tws_pkg::FILT_CYC - 1)) begin
        filt_q[i] <= raw;
        filt_cnt_q[i] <= '0;
      end else begin
        filt_cnt_q[i] <= filt_cnt_q[i] + 1'b1;
      end
    end
  end

  // Previous filtered levels for edge and condition detection.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_p_q <= 2'h3;
    end else begin
      filt_p_q <= filt_q;
    end
  end

  assign scl_rise = filt_q[0] & ~filt_p_q[0];
  assign scl_fall = ~filt_q[0] & filt_p_q[0];
  assign bus_start = filt_q[0] & filt_p_q[0] & filt_p_q[1] & ~filt_q[1];
  assign bus_stop = filt_q[0] & filt_p_q[0] & ~filt_p_q[1] & filt_q[1];

  // ------------------------------------------------------------------
  // Received-byte buffer between the sequencer and the data register.
  // ------------------------------------------------------------------
  assign fifo_in_valid = (state_q == tws_pkg::ST_PUSH);
  assign fifo_out_ready = ~byte_done_flag_q;

  tws_fifo2 #(
    .WIDTH(8)
  ) u_rx_buf (
    .clk(sys_clk),
    .rst_b(rst_b),
    .flush(slave_off),
    .in_valid(fifo_in_valid),
    .in_data(shift_q),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  // ------------------------------------------------------------------
  // Slave sequencer.
  // ------------------------------------------------------------------
  // Master mode parks the sequencer: nothing here acts on the pins then.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= tws_pkg::ST_IDLE;
      shift_q <= 8'h00;
      cnt_q <= '0;
      direction_status_bit_q <= 1'b0;
      tx_nack_q <= 1'b0;
    end else if (slave_off) begin
      state_q <= tws_pkg::ST_IDLE;
      cnt_q <= '0;
    end else if (bus_start) begin
      state_q <= tws_pkg::ST_ADDR;
      cnt_q <= '0;
    end else if (bus_stop) begin
      state_q <= tws_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        tws_pkg::ST_IDLE: begin
          cnt_q <= '0;
        end
        tws_pkg::ST_ADDR, tws_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], filt_q[1]};
            cnt_q <= cnt_q + 1'b1;
          end else if (scl_fall && cnt_q == tws_pkg::CNT_W'(tws_pkg::BYTE_BITS)) begin
            if (state_q == tws_pkg::ST_ADDR && shift_q[7:1] != slave_address_reg_q[6:0]) begin
              state_q <= tws_pkg::ST_IDLE;
            end else begin
              if (state_q == tws_pkg::ST_ADDR) begin
                direction_status_bit_q <= shift_q[0];
              end
              state_q <= tws_pkg::ST_PUSH;
            end
          end
        end
        tws_pkg::ST_PUSH: begin
          if (fifo_in_ready) begin
            state_q <= tws_pkg::ST_ACK;
          end
        end
        tws_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_q <= tws_pkg::ST_WAIT;
          end
        end
        tws_pkg::ST_WAIT: begin
          cnt_q <= '0;
          if (!byte_done_flag_q && !fifo_out_valid) begin
            if (direction_status_bit_q) begin
              shift_q <= byte_data_reg_q;
              state_q <= tws_pkg::ST_TX;
            end else begin
              state_q <= tws_pkg::ST_RX;
            end
          end
        end
        tws_pkg::ST_TX: begin
          if (scl_fall) begin
            shift_q <= {shift_q[6:0], 1'b1};
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == tws_pkg::CNT_W'(tws_pkg::BYTE_BITS - 1)) begin
              state_q <= tws_pkg::ST_TXACK;
            end
          end
        end
        tws_pkg::ST_TXACK: begin
          if (scl_rise) begin
            tx_nack_q <= filt_q[1];
          end else if (scl_fall) begin
            state_q <= tx_nack_q ? tws_pkg::ST_IDLE : tws_pkg::ST_WAIT;
          end
        end
      endcase
    end
  end

  assign tx_byte_done = (state_q == tws_pkg::ST_TXACK) & scl_rise & ~slave_off;

  // ------------------------------------------------------------------
  // Byte data register and byte-done flag.
  // ------------------------------------------------------------------
  // A new byte from the buffer or a finished transmit sets the flag; the set
  // wins over a same-cycle data register access.
  assign byte_done_flag_d = (fifo_out_valid & fifo_out_ready) | tx_byte_done
                          | (byte_done_flag_q & ~data_rd & ~data_wr);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_done_flag_q <= 1'b0;
    end else if (slave_off) begin
      byte_done_flag_q <= 1'b0;
    end else begin
      byte_done_flag_q <= byte_done_flag_d;
    end
  end

  // Software writes load the next transmit byte; received bytes arrive here.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_data_reg_q <= tws_pkg::DATA_RST;
    end else if (fifo_out_valid && fifo_out_ready) begin
      byte_data_reg_q <= fifo_out_data;
    end else if (data_wr) begin
      byte_data_reg_q <= sfr_wdata;
    end
  end

  // ------------------------------------------------------------------
  // Control and address registers.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slave_address_reg_q <= tws_pkg::SLAVE_ADDR_RST;
    end else if (sfr_wr && hit(sfr_addr, tws_pkg::ADDR_SLAVE)) begin
      slave_address_reg_q <= sfr_wdata;
    end
  end

  // Pin control bits start at zero and the port wakes as a slave.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out_bit_q <= 1'b0;
      clock_out_bit_q <= 1'b0;
      data_drive_enable_q <= 1'b0;
      master_select_bit_q <= 1'b0;
      iface_reset_bit_q <= 1'b0;
    end else if (ctrl_wr) begin
      data_out_bit_q <= sfr_wdata[tws_pkg::CTRL_DATA_OUT];
      clock_out_bit_q <= sfr_wdata[tws_pkg::CTRL_CLOCK_OUT];
      data_drive_enable_q <= sfr_wdata[tws_pkg::CTRL_DRIVE_EN];
      master_select_bit_q <= sfr_wdata[tws_pkg::CTRL_MASTER];
      iface_reset_bit_q <= sfr_wdata[tws_pkg::CTRL_RESET];
    end
  end

  // Read data is registered on the read strobe so the port comes from a flop.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      if (hit(sfr_addr, tws_pkg::ADDR_SLAVE)) begin
        sfr_rdata_q <= slave_address_reg_q;
      end else if (hit(sfr_addr, tws_pkg::ADDR_DATA)) begin
        sfr_rdata_q <= byte_data_reg_q;
      end else if (hit(sfr_addr, tws_pkg::ADDR_CTRL)) begin
        sfr_rdata_q <= {data_out_bit_q, clock_out_bit_q, data_drive_enable_q, data_in_bit_q,
                        master_select_bit_q, iface_reset_bit_q, direction_status_bit_q,
                        byte_done_flag_q};
      end else begin
        sfr_rdata_q <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers.
  // ------------------------------------------------------------------
  // In master mode the bits go straight to the pins with no sequencing; in
  // slave mode the lines are only ever pulled low, as open drain.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_out_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (master_select_bit_q) begin
      sda_out_q <= data_out_bit_q;
      sda_oe_q <= data_drive_enable_q;
      scl_out_q <= clock_out_bit_q;
      scl_oe_q <= 1'b1;
    end else begin
      sda_out_q <= 1'b0;
      sda_oe_q <= (state_q == tws_pkg::ST_ACK)
                | ((state_q == tws_pkg::ST_TX) & ~shift_q[7]);
      scl_out_q <= 1'b0;
      scl_oe_q <= (state_q == tws_pkg::ST_PUSH) | (state_q == tws_pkg::ST_WAIT);
    end
  end

  assign sfr_rdata = sfr_rdata_q;
  assign serial_data_out = sda_out_q;
  assign serial_data_oe = sda_oe_q;
  assign serial_clock_out = scl_out_q;
  assign serial_clock_oe = scl_oe_q;

endmodule // tws_port

// ===== tb/tws_monitor.sv
// Checker on the port's register bus and pin drivers.
`timescale 1ns/10ps
module tws_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic serial_clock_in,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  logic ctrl_wr;
  logic mst_q;
  logic [7:0] slv_q;
  logic [7:0] wd_q;
  logic [7:0] wd2_q;

  // Mode and address are mirrored from bus writes, never read from the design.
  assign ctrl_wr = sfr_wr && (sfr_addr == tws_pkg::ADDR_CTRL);

  // Mirror of the master-select bit.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mst_q <= 1'b0;
    end else if (ctrl_wr) begin
      mst_q <= sfr_wdata[tws_pkg::CTRL_MASTER];
    end
  end

  // Mirror of the slave address register.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slv_q <= tws_pkg::SLAVE_ADDR_RST;
    end else if (sfr_wr && sfr_addr == tws_pkg::ADDR_SLAVE) begin
      slv_q <= sfr_wdata;
    end
  end

  // Write data two cycles back. The control bits load at the write edge and the pin
  // flops copy them one edge later, so the pins are first seen two edges after the write.
  always_ff @(posedge sys_clk) begin
    wd_q <= sfr_wdata;
    wd2_q <= wd_q;
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence data_rd_s;
    sfr_rd && sfr_addr == tws_pkg::ADDR_DATA;
  endsequence
  sequence ctrl_rd_s;
    sfr_rd && sfr_addr == tws_pkg::ADDR_CTRL;
  endsequence

  reset_release_a: assert property (
    $rose(rst_b) |-> !serial_clock_oe && !serial_data_oe && sfr_rdata == 8'h00)
    else $error("pins or read data not idle after reset");
  master_clock_a: assert property (
    ctrl_wr && sfr_wdata[tws_pkg::CTRL_MASTER] |-> ##2
    serial_clock_oe && serial_clock_out == wd2_q[tws_pkg::CTRL_CLOCK_OUT])
    else $error("clock pin does not follow clock-out bit");
  data_drive_a: assert property (
    ctrl_wr && sfr_wdata[tws_pkg::CTRL_MASTER] && sfr_wdata[tws_pkg::CTRL_DRIVE_EN] |-> ##2
    serial_data_oe && serial_data_out == wd2_q[tws_pkg::CTRL_DATA_OUT])
    else $error("data pin not driven to data-out bit");
  data_release_a: assert property (
    ctrl_wr && sfr_wdata[tws_pkg::CTRL_MASTER] && !sfr_wdata[tws_pkg::CTRL_DRIVE_EN] |-> ##2
    !serial_data_oe)
    else $error("data driver left on");
  master_hold_a: assert property (
    mst_q && !ctrl_wr ##1 !ctrl_wr ##1 !ctrl_wr |->
    $stable(serial_clock_out) && $stable(serial_clock_oe) && $stable(serial_data_oe))
    else $error("master pins moved without a control write");
  slave_quiet_a: assert property (
    (!mst_q) [*2] |-> !serial_clock_out && !serial_data_out)
    else $error("slave drives a high level");
  slave_addr_a: assert property (
    sfr_rd && sfr_addr == tws_pkg::ADDR_SLAVE |=> sfr_rdata == slv_q)
    else $error("slave address read back wrong");
  flag_clear_a: assert property (
    data_rd_s ##[1:2] ctrl_rd_s |=> !sfr_rdata[tws_pkg::CTRL_DONE])
    else $error("byte-done flag survived a data read");
  iface_reset_a: assert property (
    ctrl_wr && !sfr_wdata[tws_pkg::CTRL_MASTER] && sfr_wdata[tws_pkg::CTRL_RESET] |->
    ##[1:4] (!serial_clock_oe && !serial_data_oe))
    else $error("interface reset did not release the lines");
endmodule // tws_monitor

bind tws_port tws_monitor mon_u (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .serial_clock_in(serial_clock_in), .serial_clock_out(serial_clock_out),
  .serial_clock_oe(serial_clock_oe), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));

// ===== tb/tws_bus_model.sv
// Behavioural bus master on the far side of the two-wire lines.
`timescale 1ns/10ps
module tws_bus_model (
  input wire logic link_clk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_o,
  output logic sda_o,
  output logic stuck
);
  // Open-drain drives: a 1 releases the line to its pull-up.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    stuck = 1'b0;
  end

  // Six link clocks are 72 ns, comfortably past the spike filter.
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  // Release the clock and wait while the slave stretches it, within a bound.
  task automatic rise();
    int i;
    scl_o = 1'b1;
    for (i = 0; i < 4000 && scl_line !== 1'b1; i++) begin
      tick(1);
    end
    if (i == 4000) begin
      stuck = 1'b1;
    end
    tick(6);
  endtask

  task automatic fall();
    scl_o = 1'b0;
    tick(6);
  endtask

  task automatic start();
    sda_o = 1'b0;
    tick(6);
    fall();
  endtask

  task automatic stop();
    sda_o = 1'b0;
    tick(3);
    rise();
    sda_o = 1'b1;
    tick(6);
  endtask

  // A data spike too short to count as a start; the clock then drops as for a
  // transfer, so an unfiltered spike would leave the slave taking an address.
  task automatic glitch();
    sda_o = 1'b0;
    #30;
    scl_o = 1'b0;
    sda_o = 1'b1;
    tick(6);
  endtask

  // Most significant bit first; the ninth clock returns the acknowledge.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int k = 7; k >= 0; k--) begin
      sda_o = b[k];
      tick(3);
      rise();
      fall();
    end
    sda_o = 1'b1;
    tick(3);
    rise();
    ack = ~sda_line;
    fall();
  endtask

  task automatic get_byte(input logic nack, output logic [7:0] b);
    sda_o = 1'b1;
    for (int k = 7; k >= 0; k--) begin
      tick(3);
      rise();
      b[k] = sda_line;
      fall();
    end
    sda_o = nack;
    tick(3);
    rise();
    fall();
    sda_o = 1'b1;
  endtask
endmodule // tws_bus_model

// ===== tb/tb_top.sv
// Top testbench: register accesses plus a bus master driving the port.
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] CTL = tws_pkg::ADDR_CTRL;
  localparam logic [7:0] DAT = tws_pkg::ADDR_DATA;
  logic sys_clk;
  logic link_clk;
  logic rst_b;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic serial_clock_out;
  logic serial_clock_oe;
  logic serial_data_out;
  logic serial_data_oe;
  logic scl_o;
  logic sda_o;
  logic stuck;
  logic scl_line;
  logic sda_line;
  logic ack;
  logic [7:0] r;
  logic [7:0] b;
  logic [7:0] v;
  int err_total;
  int total_checks;

  // Wired-AND lines with pull-ups: any enabled low driver wins.
  assign scl_line = ~((serial_clock_oe & ~serial_clock_out) | ~scl_o);
  assign sda_line = ~((serial_data_oe & ~serial_data_out) | ~sda_o);

  tws_port dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .serial_clock_in(scl_line), .serial_clock_out(serial_clock_out),
    .serial_clock_oe(serial_clock_oe), .serial_data_in(sda_line),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));
  tws_bus_model bm_u (.link_clk(link_clk), .scl_line(scl_line), .sda_line(sda_line),
    .scl_o(scl_o), .sda_o(sda_o), .stuck(stuck));

  // Core clock at 200 MHz; link clock offset so the two never line up.
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    link_clk = 1'b0;
    #0.7;
    forever #6 link_clk = ~link_clk;
  end

  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobes are single-cycle pulses launched on the falling edge.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    reg_rd(a, d);
    chk(d & m, e);
  endtask

  // Poll the control register; giving up counts as a mismatch.
  task automatic wait_flag();
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 800 && d[0] !== 1'b1; i++) begin
      reg_rd(CTL, d);
    end
    if (d[0] !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask

  // One master clock pulse made by software, long enough for the filter.
  task automatic mclk();
    reg_wr(CTL, 8'h08);
    repeat (20) @(negedge sys_clk);
    reg_wr(CTL, 8'h48);
    repeat (20) @(negedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    rd_chk(tws_pkg::ADDR_SLAVE, 8'hFF, tws_pkg::SLAVE_ADDR_RST);
    rd_chk(CTL, 8'hFF, 8'h00);
    rd_chk(DAT, 8'hFF, tws_pkg::DATA_RST);
    rd_chk(8'h10, 8'hFF, 8'h00);
    // Every combination of the three master drive bits.
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], 5'h08};
      reg_wr(CTL, v);
      @(negedge sys_clk);
      chk({4'h0, serial_clock_oe, serial_clock_out, serial_data_oe, serial_data_out & v[5]},
        {4'h0, 1'b1, v[6], v[5], v[7] & v[5]});
    end
    mclk();
    rd_chk(CTL, 8'hFF, 8'h58);
    bm_u.sda_o = 1'b0;
    repeat (20) @(negedge sys_clk);
    rd_chk(CTL, 8'hFF, 8'h58);
    mclk();
    rd_chk(CTL, 8'hFF, 8'h48);
    bm_u.sda_o = 1'b1;
    reg_wr(CTL, 8'h00);
    reg_wr(tws_pkg::ADDR_SLAVE, 8'h2A);
    rd_chk(tws_pkg::ADDR_SLAVE, 8'hFF, 8'h2A);
    // A short spike must not open a transfer.
    bm_u.glitch();
    bm_u.put_byte(8'h54, ack);
    chk({7'h0, ack}, 8'h00);
    bm_u.stop();
    // Master writes two bytes to the slave.
    bm_u.start();
    bm_u.put_byte(8'h54, ack);
    chk({7'h0, ack}, 8'h01);
    wait_flag();
    repeat (20) @(negedge sys_clk);
    rd_chk(CTL, 8'h0F, 8'h01);
    chk({6'h0, serial_clock_oe, scl_line}, 8'h02);
    rd_chk(DAT, 8'hFF, 8'h54);
    rd_chk(CTL, 8'h0F, 8'h00);
    bm_u.put_byte(8'hA5, ack);
    chk({7'h0, ack}, 8'h01);
    wait_flag();
    rd_chk(DAT, 8'hFF, 8'hA5);
    bm_u.stop();
    // The old address no longer matches.
    bm_u.start();
    bm_u.put_byte(8'hAA, ack);
    chk({7'h0, ack}, 8'h00);
    rd_chk(CTL, 8'h0F, 8'h00);
    bm_u.stop();
    // Master reads one byte and ends it with a not-acknowledge.
    bm_u.start();
    bm_u.put_byte(8'h55, ack);
    wait_flag();
    rd_chk(CTL, 8'h0F, 8'h03);
    reg_wr(DAT, 8'h3C);
    rd_chk(CTL, 8'h0F, 8'h02);
    bm_u.get_byte(1'b1, b);
    chk(b, 8'h3C);
    wait_flag();
    bm_u.stop();
    reg_rd(DAT, r);
    // Interface reset while the slave is stretching the clock.
    bm_u.start();
    bm_u.put_byte(8'h54, ack);
    wait_flag();
    reg_wr(CTL, 8'h04);
    repeat (10) @(negedge sys_clk);
    chk({7'h0, serial_clock_oe}, 8'h00);
    rd_chk(CTL, 8'h01, 8'h00);
    reg_wr(CTL, 8'h00);
    bm_u.stop();
    chk({7'h0, stuck}, 8'h00);
    test_done();
  end
endmodule // tb_top
